// [jtp_pkg.sv]
/*
  Shared constants and types for the test access port and debug block.
  Assumes nothing of its surroundings; it is imported by scoped names only.
*/
package jtp_pkg;

  // ****************************************
  // Instruction register
  // ****************************************
  localparam int IR_W = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET = 4'h1;
  localparam logic [3:0] OP_IDCODE = 4'h1;
  localparam logic [3:0] OP_BYPASS = 4'hf;
  localparam logic [3:0] OP_DBG_CTRL = 4'h8;
  localparam logic [3:0] OP_BP_EN = 4'h9;
  localparam logic [3:0] OP_BP_ADDR = 4'ha;
  localparam logic [3:0] OP_CHAN = 4'hb;

  // ****************************************
  // Data register lengths and fields
  // ****************************************
  localparam int DR_W = 32;
  localparam int LEN_BYPASS = 1;
  localparam int LEN_ID = 32;
  localparam int LEN_CTRL = 6;
  localparam int LEN_BPEN = 4;
  localparam int LEN_BPADDR = 18;
  localparam int LEN_CHAN = 9;
  localparam int CTRL_CHAN_EN = 0;
  localparam int CTRL_FLOW = 1;
  localparam int CTRL_STEP = 2;
  localparam int CTRL_MODE_LSB = 3;
  localparam int CHAN_CLR_BIT = 8;
  localparam int BP_NUM = 4;
  localparam int BP_ADDR_W = 16;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [3:0] BPEN_RESET = 4'h0;
  localparam logic [7:0] CHAN_RESET = 8'h00;

  // ****************************************
  // Synchroniser depths
  // ****************************************
  localparam int PIN_SYNC = 3;
  localparam int LVL_SYNC = 2;

  typedef enum logic [2:0] {
    BRK_4PROG, BRK_3P1D, BRK_2P2D, BRK_2PPRANGE, BRK_2PDRANGE
  } jtp_brk_mode_t;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } jtp_tap_state_t;

endpackage

// [jtp_tap_debug_port.sv]
/*
  Test access port controller, instruction and data registers, debug
  enable gating, break point unit and CPU-to-debugger byte channel.
  Assumes tck_i is the probe's clock, unrelated to clk_i, and that fuse and
  lock inputs are static pins; port_disable_bit_i comes from CPU logic.
*/
// Behaviour
// R1: Sixteen-state TAP machine stepped by TMS at each rising TCK edge.
// R2: After power-on the TAP machine sits in Test-Logic-Reset.
// R3: All shift paths move least significant bit first in and out.
// R4: Probe reaches Shift-IR from Run-Test/Idle with TMS 1,1,0,0.
// R5: Four-bit instruction; last bit enters on the edge leaving Shift-IR.
// R6: Shifting an instruction sends out the captured value 0x01.
// R7: Instruction takes effect only in Update-IR; exit and pause only navigate.
// R8: Probe reaches Shift-DR from Run-Test/Idle with TMS 1,0,0.
// R9: Selected data register shifts from TDI each rising edge in Shift-DR.
// R10: TDO shows the values loaded into the register during Capture-DR.
// R11: Latched data outputs change only in Update-DR.
// R12: Data access may follow instruction selection without Run-Test/Idle.
// R13: Five TCK periods with TMS high reach Test-Logic-Reset.
// R14: Breaks on flow change, single step, and four address points.
// R15: Break points configure in five program and data mixes.
// R16: Debug works only with both fuses set and no lock bit set.
// R17: Codes 0x8 to 0xB are the vendor debug instructions.
// R18: CPU write stores the byte and sets the dirty flag.
// R19: CPU read returns seven low stored bits and dirty flag on top.
// R20: The debugger clears the dirty flag after reading the byte.
// R21: Shared address reaches the channel only with fuse and debugger enable.
// R22: TAP enabled only with port fuse set and port disable bit clear.
// R23: With the port fuse clear the TAP is held in reset.
// R24: No test reset pin; reset only by power-on or TMS. The code also resets the TAP through the port gate request.
// R25: Reset and Test-Logic-Reset load the identification instruction 0x1.
// R26: TDO changes on falling TCK and is driven only while shifting.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_debug_port #(
  parameter logic [31:0] IDCODE = 32'h0000_0001
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic port_enable_fuse_i,
  input wire logic debug_enable_fuse_i,
  input wire logic lock_bit_one_i,
  input wire logic lock_bit_two_i,
  input wire logic port_disable_bit_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  input wire logic [7:0] std_rdata_i,
  output logic std_wr_o,
  output logic std_rd_o,
  output logic [7:0] std_wdata_o,
  input wire logic [15:0] pc_i,
  input wire logic pc_valid_i,
  input wire logic flow_change_i,
  input wire logic [15:0] data_addr_i,
  input wire logic data_acc_i,
  output logic break_o,
  output logic tap_active_o,
  output logic debug_active_o
);

  // ****************************************
  // Fuse and lock pins into the CPU clock
  // ****************************************
  logic [3:0] fz1_r, fz2_r, fz3_r, fz_r;
  logic tap_en_r, dbg_en_r, tck_rst_req_r;

  always_ff @(posedge clk_i) begin
    fz1_r <= {lock_bit_two_i, lock_bit_one_i, debug_enable_fuse_i, port_enable_fuse_i};
    fz2_r <= fz1_r;
    fz3_r <= fz2_r;
    if (srst_i) begin
      fz_r <= 4'h0;
    end else begin
      fz_r <= (fz2_r & fz3_r) | (fz_r & (fz2_r | fz3_r));
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tap_en_r <= 1'b0;
      dbg_en_r <= 1'b0;
      tck_rst_req_r <= 1'b1;
    end else begin
      tap_en_r <= fz_r[0] & ~port_disable_bit_i; // R22
      dbg_en_r <= fz_r[0] & ~port_disable_bit_i & fz_r[1] & ~fz_r[2] & ~fz_r[3]; // R16
      tck_rst_req_r <= ~(fz_r[0] & ~port_disable_bit_i); // R23
    end
  end

  // ****************************************
  // Levels from the CPU clock into TCK
  // ****************************************
  logic [10:0] lv1_r, lv2_r;
  logic tck_rst, dbg_en_t, dirty_t;
  logic [7:0] byte_t;
  logic dirty_r;
  logic [7:0] byte_r;

  always_ff @(posedge tck_i) begin
    lv1_r <= {srst_i | tck_rst_req_r, dbg_en_r, dirty_r, byte_r};
    lv2_r <= lv1_r;
  end

  // Power-on reset and the port gate request are the only sources besides TMS; there is no test reset pin.
  assign tck_rst = lv2_r[10]; // R24
  assign dbg_en_t = lv2_r[9];
  assign dirty_t = lv2_r[8];
  assign byte_t = lv2_r[7:0];

  // ****************************************
  // TAP state machine
  // ****************************************
  jtp_pkg::jtp_tap_state_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      jtp_pkg::ST_RESET: st_nxt = tms_i ? jtp_pkg::ST_RESET : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_IDLE: st_nxt = tms_i ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_SEL_DR: st_nxt = tms_i ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
      jtp_pkg::ST_CAP_DR: st_nxt = tms_i ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_SH_DR: st_nxt = tms_i ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_EX1_DR: st_nxt = tms_i ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAU_DR;
      jtp_pkg::ST_PAU_DR: st_nxt = tms_i ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PAU_DR;
      jtp_pkg::ST_EX2_DR: st_nxt = tms_i ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_UPD_DR: st_nxt = tms_i ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      jtp_pkg::ST_SEL_IR: st_nxt = tms_i ? jtp_pkg::ST_RESET : jtp_pkg::ST_CAP_IR;
      jtp_pkg::ST_CAP_IR: st_nxt = tms_i ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_SH_IR: st_nxt = tms_i ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_EX1_IR: st_nxt = tms_i ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAU_IR;
      jtp_pkg::ST_PAU_IR: st_nxt = tms_i ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PAU_IR;
      jtp_pkg::ST_EX2_IR: st_nxt = tms_i ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_UPD_IR: st_nxt = tms_i ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
      default: st_nxt = jtp_pkg::ST_RESET;
    endcase
  end

  // Update states lead straight back to Select-DR, so no idle pass is needed.
  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      st_r <= jtp_pkg::ST_RESET; // R2 R23
    end else begin
      st_r <= st_nxt; // R1 R13 R12
    end
  end

  // ****************************************
  // Instruction register
  // ****************************************
  logic [3:0] ir_sh_r, ir_r;

  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      ir_sh_r <= jtp_pkg::IR_CAPTURE;
      ir_r <= jtp_pkg::IR_RESET; // R25
    end else begin
      case (st_r)
        jtp_pkg::ST_RESET: begin
          ir_r <= jtp_pkg::IR_RESET; // R25
        end
        jtp_pkg::ST_CAP_IR: begin
          ir_sh_r <= jtp_pkg::IR_CAPTURE; // R6
        end
        jtp_pkg::ST_SH_IR: begin
          ir_sh_r <= {tdi_i, ir_sh_r[3:1]}; // R3 R5
        end
        jtp_pkg::ST_UPD_IR: begin
          ir_r <= ir_sh_r; // R7
        end
        default: begin
          ir_r <= ir_r;
        end
      endcase
    end
  end

  // ****************************************
  // Data register selection
  // ****************************************
  logic [3:0] sel;
  logic priv_op;
  int dr_len;

  // Vendor debug codes fall back to bypass while debugging is not allowed.
  assign priv_op = (ir_r[3:2] == 2'b10); // R17
  assign sel = (priv_op && !dbg_en_t) ? jtp_pkg::OP_BYPASS : ir_r; // R16

  always_comb begin
    case (sel)
      jtp_pkg::OP_IDCODE: dr_len = jtp_pkg::LEN_ID;
      jtp_pkg::OP_DBG_CTRL: dr_len = jtp_pkg::LEN_CTRL;
      jtp_pkg::OP_BP_EN: dr_len = jtp_pkg::LEN_BPEN;
      jtp_pkg::OP_BP_ADDR: dr_len = jtp_pkg::LEN_BPADDR;
      jtp_pkg::OP_CHAN: dr_len = jtp_pkg::LEN_CHAN;
      default: dr_len = jtp_pkg::LEN_BYPASS;
    endcase
  end

  // ****************************************
  // Data shift path and latched debug settings
  // ****************************************
  logic [31:0] dr_r, dr_sh, dr_cap;
  logic [5:0] ctrl_h_r;
  logic [3:0] bpen_h_r;
  logic [1:0] bpidx_h_r;
  logic [15:0] bpaddr_h_r;
  logic kind_h_r, upd_tgl_r, clr_tgl_r;

  always_comb begin
    dr_sh = 32'h0000_0000;
    for (int i = 0; i < jtp_pkg::DR_W; i++) begin
      if (i == dr_len - 1) begin
        dr_sh[i] = tdi_i;
      end else if (i < dr_len - 1) begin
        dr_sh[i] = dr_r[i + 1];
      end
    end
  end

  always_comb begin
    case (sel)
      jtp_pkg::OP_IDCODE: dr_cap = IDCODE;
      jtp_pkg::OP_DBG_CTRL: dr_cap = {26'h0, ctrl_h_r};
      jtp_pkg::OP_BP_EN: dr_cap = {28'h0, bpen_h_r};
      jtp_pkg::OP_BP_ADDR: dr_cap = {14'h0, bpidx_h_r, bpaddr_h_r};
      jtp_pkg::OP_CHAN: dr_cap = {23'h0, dirty_t, byte_t};
      default: dr_cap = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      dr_r <= 32'h0000_0000;
    end else if (st_r == jtp_pkg::ST_CAP_DR) begin
      dr_r <= dr_cap; // R10
    end else if (st_r == jtp_pkg::ST_SH_DR) begin
      dr_r <= dr_sh; // R3 R9
    end
  end

  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      ctrl_h_r <= jtp_pkg::CTRL_RESET;
      bpen_h_r <= jtp_pkg::BPEN_RESET;
      bpidx_h_r <= 2'h0;
      bpaddr_h_r <= 16'h0000;
      kind_h_r <= 1'b0;
      upd_tgl_r <= 1'b0;
      clr_tgl_r <= 1'b0;
    end else if (st_r == jtp_pkg::ST_UPD_DR) begin // R11
      case (sel)
        jtp_pkg::OP_DBG_CTRL: begin
          ctrl_h_r <= dr_r[5:0];
          kind_h_r <= 1'b0;
          upd_tgl_r <= ~upd_tgl_r;
        end
        jtp_pkg::OP_BP_EN: begin
          bpen_h_r <= dr_r[3:0];
          kind_h_r <= 1'b0;
          upd_tgl_r <= ~upd_tgl_r;
        end
        jtp_pkg::OP_BP_ADDR: begin
          bpidx_h_r <= dr_r[17:16];
          bpaddr_h_r <= dr_r[15:0];
          kind_h_r <= 1'b1;
          upd_tgl_r <= ~upd_tgl_r;
        end
        jtp_pkg::OP_CHAN: begin
          if (dr_r[jtp_pkg::CHAN_CLR_BIT]) begin
            clr_tgl_r <= ~clr_tgl_r; // R20
          end
        end
        default: begin
          kind_h_r <= kind_h_r;
        end
      endcase
    end
  end

  // ****************************************
  // TDO on the falling edge
  // ****************************************
  always_ff @(negedge tck_i) begin
    if (tck_rst) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_o <= (st_r == jtp_pkg::ST_SH_IR) ? ir_sh_r[0] : dr_r[0]; // R26 R3
      tdo_oe_o <= (st_r == jtp_pkg::ST_SH_IR) || (st_r == jtp_pkg::ST_SH_DR); // R26
    end
  end

  // ****************************************
  // Events from TCK into the CPU clock
  // ****************************************
  logic [1:0] ev1_r, ev2_r, ev3_r;
  logic upd_evt, clr_evt;

  always_ff @(posedge clk_i) begin
    ev1_r <= {clr_tgl_r, upd_tgl_r};
    ev2_r <= ev1_r;
    ev3_r <= ev2_r;
  end

  assign upd_evt = ev2_r[0] ^ ev3_r[0];
  assign clr_evt = ev2_r[1] ^ ev3_r[1];

  // ****************************************
  // Break point settings in the CPU clock
  // ****************************************
  logic chan_en_r, flow_r, step_r;
  jtp_pkg::jtp_brk_mode_t mode_r;
  logic [3:0] bp_en_r;
  logic [15:0] bp_addr_r [jtp_pkg::BP_NUM];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      chan_en_r <= 1'b0;
      flow_r <= 1'b0;
      step_r <= 1'b0;
      mode_r <= jtp_pkg::BRK_4PROG;
      bp_en_r <= jtp_pkg::BPEN_RESET;
    end else if (upd_evt) begin
      chan_en_r <= ctrl_h_r[jtp_pkg::CTRL_CHAN_EN];
      flow_r <= ctrl_h_r[jtp_pkg::CTRL_FLOW];
      step_r <= ctrl_h_r[jtp_pkg::CTRL_STEP];
      mode_r <= jtp_pkg::jtp_brk_mode_t'(ctrl_h_r[5:3]); // R15
      bp_en_r <= bpen_h_r;
    end
  end

  logic [3:0] hit;
  logic range_mode;

  assign range_mode = (mode_r == jtp_pkg::BRK_2PPRANGE) || (mode_r == jtp_pkg::BRK_2PDRANGE);

  for (genvar g = 0; g < jtp_pkg::BP_NUM; g++) begin : g_bp
    logic is_data, is_range, is_mask;
    logic [15:0] cmp_a, msk;

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        bp_addr_r[g] <= 16'h0000;
      end else if (upd_evt && kind_h_r && (bpidx_h_r == 2'(g))) begin
        bp_addr_r[g] <= bpaddr_h_r;
      end
    end

    // In range mixes the last point is the mask of the one before it.
    assign is_range = range_mode && (g == 2); // R15
    assign is_mask = range_mode && (g == 3);
    assign is_data = ((mode_r == jtp_pkg::BRK_3P1D) && (g == 3)) ||
                     ((mode_r == jtp_pkg::BRK_2P2D) && (g >= 2)) ||
                     ((mode_r == jtp_pkg::BRK_2PDRANGE) && (g == 2)); // R15
    assign cmp_a = is_data ? data_addr_i : pc_i;
    assign msk = is_range ? bp_addr_r[3] : 16'hffff;
    assign hit[g] = bp_en_r[g] && !is_mask && (is_data ? data_acc_i : pc_valid_i) &&
                    ((cmp_a & msk) == (bp_addr_r[g] & msk)); // R14
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      break_o <= 1'b0;
    end else begin
      break_o <= dbg_en_r && ((|hit) || (flow_r && flow_change_i) ||
                 (step_r && pc_valid_i)); // R14 R16
    end
  end

  // ****************************************
  // CPU byte channel and shared address
  // ****************************************
  logic chan_route;

  assign chan_route = fz_r[1] && chan_en_r && dbg_en_r; // R21

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      byte_r <= jtp_pkg::CHAN_RESET;
      dirty_r <= 1'b0;
    end else if (cpu_wr_i && chan_route) begin
      byte_r <= cpu_wdata_i; // R18
      dirty_r <= 1'b1; // R18
    end else if (clr_evt) begin
      dirty_r <= 1'b0; // R20
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cpu_rdata_o <= 8'h00;
      std_wr_o <= 1'b0;
      std_rd_o <= 1'b0;
      std_wdata_o <= 8'h00;
    end else begin
      if (cpu_rd_i) begin
        cpu_rdata_o <= chan_route ? {dirty_r, byte_r[6:0]} : std_rdata_i; // R19 R21
      end
      std_wr_o <= cpu_wr_i && !chan_route; // R21
      std_rd_o <= cpu_rd_i && !chan_route; // R21
      std_wdata_o <= cpu_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tap_active_o <= 1'b0;
      debug_active_o <= 1'b0;
    end else begin
      tap_active_o <= tap_en_r; // R23
      debug_active_o <= dbg_en_r; // R16
    end
  end

endmodule
`default_nettype wire

// [jtp_tap_debug_port_checker.sv]
/*
  Concurrent checks on the test port and CPU-side ports of the block.
  Assumes it is bound to every instance of the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_debug_port_checker #(
  parameter logic [31:0] IDCODE = 32'h0000_0001
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic port_enable_fuse_i,
  input wire logic lock_bit_one_i,
  input wire logic lock_bit_two_i,
  input wire logic port_disable_bit_i,
  input wire logic cpu_wr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic std_wr_o,
  input wire logic [7:0] std_wdata_o,
  input wire logic break_o,
  input wire logic tap_active_o,
  input wire logic debug_active_o
);
  // ********
  // Shadow of the controller state, instruction and shift count
  // ********
  localparam logic [63:0] NX0 = 64'h1bddbba146644311;
  localparam logic [63:0] NX1 = 64'h2fefcc0287855920;
  logic [3:0] st;
  logic [3:0] ir_sh;
  logic [3:0] ir;
  logic [5:0] cnt;
  logic off;
  assign off = srst_i || !tap_active_o;

  always_ff @(posedge tck_i) begin
    if (off) begin
      st <= 4'h0;
      ir <= jtp_pkg::IR_RESET;
      cnt <= 6'h00;
    end else begin
      st <= tms_i ? NX1[{st, 2'b00} +: 4] : NX0[{st, 2'b00} +: 4];
      cnt <= (st == jtp_pkg::ST_SH_IR || st == jtp_pkg::ST_SH_DR) ? cnt + 6'h01 : 6'h00;
      if (st == jtp_pkg::ST_SH_IR) ir_sh <= {tdi_i, ir_sh[3:1]};
      if (st == jtp_pkg::ST_UPD_IR) ir <= ir_sh;
      if (st == jtp_pkg::ST_RESET) ir <= jtp_pkg::IR_RESET;
    end
  end

  // ********
  // Assertions
  // ********
  a_oe_in_shift: assert property (@(posedge tck_i) disable iff (off)
    tdo_oe_o == (st == jtp_pkg::ST_SH_IR || st == jtp_pkg::ST_SH_DR))
    else $error("tdo enable does not follow the shift states");
  a_ir_capture_out: assert property (@(posedge tck_i) disable iff (off)
    st == jtp_pkg::ST_SH_IR && cnt < 6'h04 |-> tdo_o == jtp_pkg::IR_CAPTURE[cnt[1:0]])
    else $error("wrong captured instruction bit on tdo");
  a_id_default: assert property (@(posedge tck_i) disable iff (off)
    ir == jtp_pkg::OP_IDCODE && st == jtp_pkg::ST_SH_DR && cnt < 6'h20
    |-> tdo_o == IDCODE[cnt[4:0]])
    else $error("wrong identification bit on tdo");
  a_bypass_delay: assert property (@(posedge tck_i) disable iff (off)
    ir == jtp_pkg::OP_BYPASS && st == jtp_pkg::ST_SH_DR
    |-> tdo_o == ((cnt == 6'h00) ? 1'b0 : $past(tdi_i)))
    else $error("bypass path does not delay tdi by one stage");
  a_tms_reset: assert property (@(posedge tck_i) disable iff (off)
    tms_i [*5] |=> !tdo_oe_o)
    else $error("tdo still driven after five tms high");
  a_tap_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    port_disable_bit_i [*4] |-> !tap_active_o)
    else $error("port active while disabled");
  a_fuse_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    !port_enable_fuse_i [*8] |-> !tap_active_o)
    else $error("port active with its fuse clear");
  a_lock_gate: assert property (@(posedge clk_i) disable iff (srst_i)
    (lock_bit_one_i || lock_bit_two_i) [*8] |-> !debug_active_o)
    else $error("debug active while locked");
  a_std_write: assert property (@(posedge clk_i) disable iff (srst_i)
    cpu_wr_i && !debug_active_o ##1 !debug_active_o
    |-> std_wr_o && std_wdata_o == $past(cpu_wdata_i))
    else $error("write did not reach the ordinary register");

  c_ir_shift: cover property (@(posedge tck_i) st == jtp_pkg::ST_SH_IR);
  c_break: cover property (@(posedge clk_i) break_o);
  c_std_wr: cover property (@(posedge clk_i) std_wr_o);
endmodule

bind jtp_tap_debug_port jtp_tap_debug_port_checker #(.IDCODE(IDCODE)) u_chk (.clk_i, .srst_i,
  .tck_i, .tms_i, .tdi_i, .tdo_o, .tdo_oe_o, .port_enable_fuse_i, .lock_bit_one_i,
  .lock_bit_two_i, .port_disable_bit_i, .cpu_wr_i, .cpu_wdata_i, .std_wr_o, .std_wdata_o,
  .break_o, .tap_active_o, .debug_active_o);
`default_nettype wire

// [jtp_probe_model.sv]
/*
  Behavioural model of the external test controller.
  Assumes the bench calls one task at a time; tck rests low between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module jtp_probe_model (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  // ********
  // Frame tasks
  // ********
  // A chained frame ends in Select-DR, so the next frame skips Run-Test/Idle.
  logic chain = 1'b0;
  logic at_sel = 1'b0;

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // Lines change with the falling edge; tdo is taken at the rising edge.
  task automatic tick(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #16 tck_o = 1'b1;
    q = tdo_i;
    #16 tck_o = 1'b0;
  endtask

  task automatic reset_tap();
    logic b;
    repeat (6) tick(1'b1, ~tdi_o, b);
    tick(1'b0, ~tdi_o, b);
    at_sel = 1'b0;
  endtask

  task automatic scan(input logic ir, input int n, input logic [31:0] d,
    output logic [31:0] q);
    logic b;
    q = 32'h0;
    if (!at_sel) tick(1'b1, ~tdi_o, b);
    if (ir) tick(1'b1, ~tdi_o, b);
    tick(1'b0, ~tdi_o, b);
    tick(1'b0, ~tdi_o, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i], b);
      q[i] = b;
    end
    tick(1'b1, ~tdi_o, b);
    tick(chain, ~tdi_o, b);
    at_sel = chain;
  endtask
endmodule
`default_nettype wire

// [jtp_tap_debug_port_tb.sv]
/*
  Self-checking bench for the test port and debug block.
  Assumes the probe model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] IDC = 32'h0a5c_3e71; // Arbitrary identification value.
  logic clk_i, srst_i, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, cpu_wr_i, cpu_rd_i;
  logic port_enable_fuse_i, debug_enable_fuse_i, lock_bit_one_i, lock_bit_two_i;
  logic port_disable_bit_i, std_wr_o, std_rd_o, pc_valid_i, flow_change_i, data_acc_i;
  logic break_o, tap_active_o, debug_active_o;
  logic [7:0] cpu_wdata_i, cpu_rdata_o, std_rdata_i, std_wdata_o;
  logic [15:0] pc_i, data_addr_i;
  logic [31:0] q;
  logic [5:0] ctrl;
  int errors, n_tests;

  jtp_tap_debug_port #(.IDCODE(IDC)) dut (.clk_i, .srst_i, .tck_i, .tms_i, .tdi_i, .tdo_o,
    .tdo_oe_o, .port_enable_fuse_i, .debug_enable_fuse_i, .lock_bit_one_i, .lock_bit_two_i,
    .port_disable_bit_i, .cpu_wr_i, .cpu_rd_i, .cpu_wdata_i, .cpu_rdata_o, .std_rdata_i,
    .std_wr_o, .std_rd_o, .std_wdata_o, .pc_i, .pc_valid_i, .flow_change_i, .data_addr_i,
    .data_acc_i, .break_o, .tap_active_o, .debug_active_o);
  // A released tdo line reads as its pull-up level.
  jtp_probe_model u_probe (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
    .tdo_i(tdo_oe_o ? tdo_o : 1'b1));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ********
  // Access tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic clks(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic do_reset();
    srst_i = 1'b1;
    fork
      clks(16);
      u_probe.reset_tap();
    join
    srst_i = 1'b0;
    clks(12);
    u_probe.reset_tap();
  endtask

  task automatic ir(input logic [3:0] op);
    u_probe.scan(1'b1, 4, {28'h0, op}, q);
    chk(q, {28'h0, jtp_pkg::IR_CAPTURE}, "captured instruction");
  endtask

  task automatic dr(input int n, input logic [31:0] d, input logic [31:0] e, input string w);
    u_probe.scan(1'b0, n, d, q);
    chk(q, e, w);
  endtask

  task automatic set_ctrl(input logic [5:0] v);
    ir(jtp_pkg::OP_DBG_CTRL);
    dr(6, {26'h0, v}, {26'h0, ctrl}, "control readback");
    ctrl = v;
    clks(8);
  endtask

  task automatic cpu_wr(input logic [7:0] d, input logic std);
    @(negedge clk_i);
    cpu_wr_i = 1'b1;
    cpu_wdata_i = d;
    @(negedge clk_i);
    cpu_wr_i = 1'b0;
    chk({31'h0, std_wr_o}, {31'h0, std}, "ordinary write strobe");
    if (std) chk({24'h0, std_wdata_o}, {24'h0, d}, "ordinary write data");
  endtask

  task automatic cpu_rd(input logic [7:0] e, input logic std);
    @(negedge clk_i);
    cpu_rd_i = 1'b1;
    @(negedge clk_i);
    cpu_rd_i = 1'b0;
    chk({24'h0, cpu_rdata_o}, {24'h0, e}, "channel read");
    chk({31'h0, std_rd_o}, {31'h0, std}, "ordinary read strobe");
  endtask

  task automatic brk(input logic [15:0] a, input logic pv, input logic fc, input logic da,
    input logic e);
    logic seen;
    seen = 1'b0;
    @(negedge clk_i);
    pc_i = a;
    data_addr_i = a;
    pc_valid_i = pv;
    flow_change_i = fc;
    data_acc_i = da;
    @(negedge clk_i);
    pc_valid_i = 1'b0;
    flow_change_i = 1'b0;
    data_acc_i = 1'b0;
    repeat (3) begin
      seen = seen | break_o;
      @(negedge clk_i);
    end
    chk({31'h0, seen}, {31'h0, e}, "break");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    errors = 0;
    n_tests = 0;
    ctrl = jtp_pkg::CTRL_RESET;
    {port_enable_fuse_i, debug_enable_fuse_i} = 2'b11;
    {lock_bit_one_i, lock_bit_two_i, port_disable_bit_i} = 3'b000;
    {cpu_wr_i, cpu_rd_i, pc_valid_i, flow_change_i, data_acc_i} = 5'h00;
    {cpu_wdata_i, std_rdata_i, pc_i, data_addr_i} = 48'h0;
    do_reset();
    dr(32, 32'h0, IDC, "default identification");
    cpu_wr(8'h77, 1'b1);
    u_probe.chain = 1'b1;
    ir(jtp_pkg::OP_BYPASS);
    u_probe.chain = 1'b0;
    dr(8, 32'h5a, 32'hb4, "bypass after chained update");
    u_probe.reset_tap();
    dr(32, 32'h0, IDC, "identification after tms reset");
    $display("test reset and bypass done");
    set_ctrl(6'h01);
    set_ctrl(6'h01);
    chk({31'h0, debug_active_o}, 32'h1, "debug enabled");
    cpu_wr(8'h3c, 1'b0);
    cpu_rd(8'hbc, 1'b0);
    ir(jtp_pkg::OP_CHAN);
    dr(9, 32'h100, 32'h13c, "channel capture");
    clks(8);
    cpu_rd(8'h3c, 1'b0);
    $display("test channel done");
    set_ctrl(6'h04);
    brk(16'h1111, 1'b1, 1'b0, 1'b0, 1'b1);
    set_ctrl(6'h02);
    brk(16'h1111, 1'b1, 1'b1, 1'b0, 1'b1);
    brk(16'h1111, 1'b1, 1'b0, 1'b0, 1'b0);
    ir(jtp_pkg::OP_BP_ADDR);
    dr(18, {14'h0, 2'h2, 16'h0450}, 32'h0, "break address reset");
    ir(jtp_pkg::OP_BP_ADDR);
    dr(18, {14'h0, 2'h3, 16'hfff0}, 32'h0002_0450, "break address readback");
    ir(jtp_pkg::OP_BP_EN);
    dr(4, 32'hc, {28'h0, jtp_pkg::BPEN_RESET}, "break enables");
    for (int m = 0; m < 5; m++) begin
      set_ctrl({m[2:0], 3'b000});
      brk((m < 3) ? 16'hfff0 : 16'h0457, 1'b1, 1'b0, 1'b0, m == 0 || m == 3);
      brk((m < 3) ? 16'hfff0 : 16'h0457, 1'b0, 1'b0, 1'b1, m == 1 || m == 2 || m == 4);
    end
    $display("test break modes done");
    lock_bit_two_i = 1'b1;
    clks(12);
    chk({31'h0, debug_active_o}, 32'h0, "debug with lock two");
    ir(jtp_pkg::OP_DBG_CTRL);
    dr(6, 32'h2a, 32'h14, "locked control as bypass");
    cpu_wr(8'h11, 1'b1);
    std_rdata_i = 8'h5e;
    cpu_rd(8'h5e, 1'b1);
    lock_bit_two_i = 1'b0;
    lock_bit_one_i = 1'b1;
    clks(12);
    chk({31'h0, debug_active_o}, 32'h0, "debug with lock one");
    lock_bit_one_i = 1'b0;
    port_disable_bit_i = 1'b1;
    clks(8);
    chk({31'h0, tap_active_o}, 32'h0, "port disabled");
    dr(8, 32'h00, 32'hff, "port held with tdo released");
    clks(1);
    port_disable_bit_i = 1'b0;
    port_enable_fuse_i = 1'b0;
    clks(12);
    chk({31'h0, tap_active_o}, 32'h0, "port fuse clear");
    port_enable_fuse_i = 1'b1;
    clks(12);
    u_probe.reset_tap();
    dr(32, 32'h0, IDC, "identification after re-enable");
    $display("test gating done");
    give_verdict();
  end
endmodule
`default_nettype wire
